// ===== rtl/scr_pkg.sv
// constants, field layout and types of the serial lane configuration bank
package scr_pkg;

  localparam int unsigned SCR_ADDR_W = 18;
  localparam int unsigned SCR_DATA_W = 8;
  localparam int unsigned SCR_NUM_CH = 4;
  localparam int unsigned SCR_NUM_QUAD = 2;

  //////////////////////////////////////////////////////////////////////////////
  // register offsets, system address space; channel order AC, AD, BC, BD
  localparam logic [17:0] SCR_LANE_TX_CFG_AC_OFS = 18'h30022;
  localparam logic [17:0] SCR_LANE_RX_CFG_AC_OFS = 18'h30023;
  localparam logic [17:0] SCR_LANE_TX_CFG_AD_OFS = 18'h30032;
  localparam logic [17:0] SCR_LANE_RX_CFG_AD_OFS = 18'h30033;
  localparam logic [17:0] SCR_LANE_TX_CFG_BC_OFS = 18'h30122;
  localparam logic [17:0] SCR_LANE_RX_CFG_BC_OFS = 18'h30123;
  localparam logic [17:0] SCR_LANE_TX_CFG_BD_OFS = 18'h30132;
  localparam logic [17:0] SCR_LANE_RX_CFG_BD_OFS = 18'h30133;

  localparam logic [17:0] SCR_TX_OFS [SCR_NUM_CH] = '{
    SCR_LANE_TX_CFG_AC_OFS, SCR_LANE_TX_CFG_AD_OFS,
    SCR_LANE_TX_CFG_BC_OFS, SCR_LANE_TX_CFG_BD_OFS};
  localparam logic [17:0] SCR_RX_OFS [SCR_NUM_CH] = '{
    SCR_LANE_RX_CFG_AC_OFS, SCR_LANE_RX_CFG_AD_OFS,
    SCR_LANE_RX_CFG_BC_OFS, SCR_LANE_RX_CFG_BD_OFS};

  //////////////////////////////////////////////////////////////////////////////
  // reset values and writable bits
  localparam logic [7:0] SCR_TX_CFG_RST = 8'h00;
  localparam logic [7:0] SCR_RX_CFG_RST = 8'h20;
  localparam logic [7:0] SCR_TX_RW_MASK = 8'hff;
  // the three low data bits of the receive register are not implemented
  localparam logic [7:0] SCR_RX_RW_MASK = 8'hf8;

  //////////////////////////////////////////////////////////////////////////////
  // field positions in the data byte; the bit column counts from the msb
  localparam int unsigned SCR_TX_HALF_RATE_BIT = 7;
  localparam int unsigned SCR_TX_PWRDN_BIT = 6;
  localparam int unsigned SCR_TX_EMPH0_BIT = 5;
  localparam int unsigned SCR_TX_EMPH1_BIT = 4;
  localparam int unsigned SCR_TX_HALF_SWING_BIT = 3;
  localparam int unsigned SCR_TX_RSVD5_BIT = 2;
  localparam int unsigned SCR_TX_ENCODE_BIT = 0;
  localparam int unsigned SCR_RX_HALF_RATE_BIT = 7;
  localparam int unsigned SCR_RX_PWRDN_BIT = 6;
  localparam int unsigned SCR_RX_RSVD2_BIT = 5;
  localparam int unsigned SCR_RX_DECODE_BIT = 4;
  localparam int unsigned SCR_RX_LINK_FSM_BIT = 3;

  //////////////////////////////////////////////////////////////////////////////
  // rates relative to the quad reference clock
  localparam logic [4:0] SCR_BAUD_MULT_HALF = 5'h0a;
  localparam logic [4:0] SCR_BAUD_MULT_FULL = 5'h14;
  localparam int unsigned SCR_DIV_CNT_W = 3;
  localparam logic [2:0] SCR_DIV_HALF_RATE = 3'h4;
  localparam logic [2:0] SCR_DIV_FULL_RATE = 3'h2;

  typedef enum logic [1:0] {
    SCR_EMPH_0 = 2'h0,
    SCR_EMPH_12P5 = 2'h1,
    SCR_EMPH_25 = 2'h2
  } scr_emph_t;

endpackage : scr_pkg

// ===== rtl/scr_div_if.sv
// link between the bank and one parallel clock enable divider
`timescale 1ns/1ps
`default_nettype none

interface scr_div_if;
  logic quarter_sel;
  logic pclk_en;
  modport ctl (output quarter_sel, input pclk_en);
  modport div (input quarter_sel, output pclk_en);
endinterface : scr_div_if

`default_nettype wire

// ===== rtl/scr_clk_div.sv
// divider that makes the parallel clock enable from the reference clock
`timescale 1ns/1ps
`default_nettype none

module scr_clk_div
  import scr_pkg::*;
#(
  parameter int unsigned CNT_W = SCR_DIV_CNT_W
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  scr_div_if.div dv
);

  if (CNT_W < 3) begin : g_bad_width
    $error("scr_clk_div: CNT_W must hold a count of four");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] last;
  logic en_q;
  logic en_d;

  //////////////////////////////////////////////////////////////////////////////
  // a rate change mid-period ends the current period at once when the count is
  // already at or past the new end, so the enable never stalls longer than the new period
  always_comb begin
    last = dv.quarter_sel ? CNT_W'(SCR_DIV_HALF_RATE - 3'h1) : CNT_W'(SCR_DIV_FULL_RATE - 3'h1);
    en_d = (cnt_q >= last);
    cnt_d = en_d ? '0 : cnt_q + CNT_W'(1);
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= '0;
      en_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      en_q <= en_d;
    end
  end

  assign dv.pclk_en = en_q;

endmodule : scr_clk_div

`default_nettype wire

// ===== rtl/scr_lane_cfg.sv
// transmit and receive configuration bank for four serial lane channels
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - a set transmit half-rate bit gives a serial rate of ten times the reference and, on a quad's first channel, a transmit parallel clock of a quarter of it.
// - a clear transmit half-rate bit, the reset state, gives twenty times the reference and, on a quad's first channel, a transmit parallel clock of half of it.
// - the transmit power-down bit powers down the channel transmitter and resets to zero.
// - the two emphasis bits give 0% when both clear, 12.5% when one is set and 25% when both are set, resetting to zero.
// - the half-swing bit halves the transmit amplitude, full swing being the reset state.
// - the encode enable bit turns on 8b/10b transmit encoding, off at reset meaning raw data.
// - a set receive half-rate bit expects ten times the reference and, on a quad's first channel, gives a receive parallel clock of a quarter of it.
// - a clear receive half-rate bit, the reset state, expects twenty times the reference and, on a quad's first channel, a receive parallel clock of half of it.
// - the receive power-down bit powers down the channel receiver and resets to zero.
// - the decode enable bit turns on 8b/10b receive decoding, off at reset meaning raw data.
// - the link state machine enable bit turns the receive link state machine on or off, off at reset.
// - the link state machine enable bit is disregarded while the channel is in four-lane mode.
// - reserved receive bit 2 is one after reset, so the receive register reads nonzero.
// - the processor port and the user master port reach the same registers at the same 18-bit address.
////////////////////////////////////////////////////////////////////////////////

module scr_lane_cfg
  import scr_pkg::*;
#(
  parameter int unsigned ADDR_W = SCR_ADDR_W
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_mpi_req,
  input wire logic i_mpi_we,
  input wire logic [ADDR_W-1:0] i_mpi_addr,
  input wire logic [SCR_DATA_W-1:0] i_mpi_wdata,
  output logic o_mpi_ack,
  output logic [SCR_DATA_W-1:0] o_mpi_rdata,
  input wire logic i_umi_req,
  input wire logic i_umi_we,
  input wire logic [ADDR_W-1:0] i_umi_addr,
  input wire logic [SCR_DATA_W-1:0] i_umi_wdata,
  output logic o_umi_ack,
  output logic [SCR_DATA_W-1:0] o_umi_rdata,
  input wire logic [SCR_NUM_CH-1:0] i_four_lane_mode_sel,
  output logic [SCR_NUM_CH-1:0][4:0] o_tx_baud_mult,
  output logic [SCR_NUM_CH-1:0] o_tx_power_down,
  output logic [SCR_NUM_CH-1:0][1:0] o_tx_emph_level,
  output logic [SCR_NUM_CH-1:0] o_tx_half_swing,
  output logic [SCR_NUM_CH-1:0] o_tx_line_encode_en,
  output logic [SCR_NUM_QUAD-1:0] o_tx_pclk_en,
  output logic [SCR_NUM_CH-1:0][4:0] o_rx_baud_mult,
  output logic [SCR_NUM_CH-1:0] o_rx_power_down,
  output logic [SCR_NUM_CH-1:0] o_rx_line_decode_en,
  output logic [SCR_NUM_CH-1:0] o_rx_link_fsm_en,
  output logic [SCR_NUM_QUAD-1:0] o_rx_pclk_en
);

  if (ADDR_W != SCR_ADDR_W) begin : g_bad_addr
    $error("scr_lane_cfg: the system address is 18 bits wide");
  end

  //////////////////////////////////////////////////////////////////////////////
  // access selection between the two masters
  logic mpi_go;
  logic umi_go;
  logic acc_go;
  logic acc_we;
  logic [ADDR_W-1:0] acc_addr;
  logic [SCR_DATA_W-1:0] acc_wdata;

  logic mpi_ack_q;
  logic mpi_ack_d;
  logic umi_ack_q;
  logic umi_ack_d;
  logic [SCR_DATA_W-1:0] mpi_rdata_q;
  logic [SCR_DATA_W-1:0] mpi_rdata_d;
  logic [SCR_DATA_W-1:0] umi_rdata_q;
  logic [SCR_DATA_W-1:0] umi_rdata_d;

  // a request is held until its ack; the ack cycle itself is skipped so a
  // held request is served once. the processor wins a tie, the user waits
  always_comb begin
    mpi_go = i_mpi_req & ~mpi_ack_q;
    umi_go = i_umi_req & ~umi_ack_q & ~mpi_go;
    acc_go = mpi_go | umi_go;
    acc_we = mpi_go ? i_mpi_we : i_umi_we;
    acc_addr = mpi_go ? i_mpi_addr : i_umi_addr;
    acc_wdata = mpi_go ? i_mpi_wdata : i_umi_wdata;
  end

  //////////////////////////////////////////////////////////////////////////////
  // register storage and decode
  logic [SCR_NUM_CH-1:0][SCR_DATA_W-1:0] tx_q;
  logic [SCR_NUM_CH-1:0][SCR_DATA_W-1:0] tx_d;
  logic [SCR_NUM_CH-1:0][SCR_DATA_W-1:0] rx_q;
  logic [SCR_NUM_CH-1:0][SCR_DATA_W-1:0] rx_d;
  logic [SCR_DATA_W-1:0] rd_mux;

  // unmapped addresses read as zero and ignore writes; a read returns the
  // value held before any write in the same access
  always_comb begin
    tx_d = tx_q;
    rx_d = rx_q;
    rd_mux = '0;
    for (int c = 0; c < SCR_NUM_CH; c++) begin
      if (acc_addr == SCR_TX_OFS[c]) begin
        rd_mux = tx_q[c];
        if (acc_go && acc_we) begin
          // reserved bit 5 is stored as written; software keeps it zero
          tx_d[c] = acc_wdata & SCR_TX_RW_MASK;
        end
      end
      if (acc_addr == SCR_RX_OFS[c]) begin
        rd_mux = rx_q[c];
        if (acc_go && acc_we) begin
          rx_d[c] = acc_wdata & SCR_RX_RW_MASK;
        end
      end
    end
  end

  always_comb begin
    mpi_ack_d = mpi_go;
    umi_ack_d = umi_go;
    mpi_rdata_d = mpi_go ? rd_mux : mpi_rdata_q;
    umi_rdata_d = umi_go ? rd_mux : umi_rdata_q;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int c = 0; c < SCR_NUM_CH; c++) begin
        tx_q[c] <= SCR_TX_CFG_RST;
        rx_q[c] <= SCR_RX_CFG_RST;
      end
      mpi_ack_q <= 1'b0;
      umi_ack_q <= 1'b0;
      mpi_rdata_q <= '0;
      umi_rdata_q <= '0;
    end else begin
      tx_q <= tx_d;
      rx_q <= rx_d;
      mpi_ack_q <= mpi_ack_d;
      umi_ack_q <= umi_ack_d;
      mpi_rdata_q <= mpi_rdata_d;
      umi_rdata_q <= umi_rdata_d;
    end
  end

  assign o_mpi_ack = mpi_ack_q;
  assign o_umi_ack = umi_ack_q;
  assign o_mpi_rdata = mpi_rdata_q;
  assign o_umi_rdata = umi_rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // per-channel controls, registered so each output leaves a flip-flop
  logic [SCR_NUM_CH-1:0][4:0] tx_mult_q;
  logic [SCR_NUM_CH-1:0][4:0] tx_mult_d;
  logic [SCR_NUM_CH-1:0][4:0] rx_mult_q;
  logic [SCR_NUM_CH-1:0][4:0] rx_mult_d;
  logic [SCR_NUM_CH-1:0][1:0] emph_q;
  logic [SCR_NUM_CH-1:0][1:0] emph_d;
  logic [SCR_NUM_CH-1:0] tx_pd_q;
  logic [SCR_NUM_CH-1:0] tx_pd_d;
  logic [SCR_NUM_CH-1:0] swing_q;
  logic [SCR_NUM_CH-1:0] swing_d;
  logic [SCR_NUM_CH-1:0] enc_q;
  logic [SCR_NUM_CH-1:0] enc_d;
  logic [SCR_NUM_CH-1:0] rx_pd_q;
  logic [SCR_NUM_CH-1:0] rx_pd_d;
  logic [SCR_NUM_CH-1:0] dec_q;
  logic [SCR_NUM_CH-1:0] dec_d;
  logic [SCR_NUM_CH-1:0] lsm_q;
  logic [SCR_NUM_CH-1:0] lsm_d;

  always_comb begin
    for (int c = 0; c < SCR_NUM_CH; c++) begin
      tx_mult_d[c] = tx_q[c][SCR_TX_HALF_RATE_BIT] ? SCR_BAUD_MULT_HALF
                                                   : SCR_BAUD_MULT_FULL;
      rx_mult_d[c] = rx_q[c][SCR_RX_HALF_RATE_BIT] ? SCR_BAUD_MULT_HALF
                                                   : SCR_BAUD_MULT_FULL;
      tx_pd_d[c] = tx_q[c][SCR_TX_PWRDN_BIT];
      case ({tx_q[c][SCR_TX_EMPH1_BIT], tx_q[c][SCR_TX_EMPH0_BIT]})
        2'h0: begin
          emph_d[c] = SCR_EMPH_0;
        end
        2'h3: begin
          emph_d[c] = SCR_EMPH_25;
        end
        default: begin
          emph_d[c] = SCR_EMPH_12P5;
        end
      endcase
      swing_d[c] = tx_q[c][SCR_TX_HALF_SWING_BIT];
      enc_d[c] = tx_q[c][SCR_TX_ENCODE_BIT];
      rx_pd_d[c] = rx_q[c][SCR_RX_PWRDN_BIT];
      dec_d[c] = rx_q[c][SCR_RX_DECODE_BIT];
      // four-lane mode runs its own link logic and masks this enable
      lsm_d[c] = rx_q[c][SCR_RX_LINK_FSM_BIT]
               & ~i_four_lane_mode_sel[c];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_mult_q <= {SCR_NUM_CH{SCR_BAUD_MULT_FULL}};
      rx_mult_q <= {SCR_NUM_CH{SCR_BAUD_MULT_FULL}};
      emph_q <= '0;
      tx_pd_q <= '0;
      swing_q <= '0;
      enc_q <= '0;
      rx_pd_q <= '0;
      dec_q <= '0;
      lsm_q <= '0;
    end else begin
      tx_mult_q <= tx_mult_d;
      rx_mult_q <= rx_mult_d;
      emph_q <= emph_d;
      tx_pd_q <= tx_pd_d;
      swing_q <= swing_d;
      enc_q <= enc_d;
      rx_pd_q <= rx_pd_d;
      dec_q <= dec_d;
      lsm_q <= lsm_d;
    end
  end

  assign o_tx_baud_mult = tx_mult_q;
  assign o_rx_baud_mult = rx_mult_q;
  assign o_tx_emph_level = emph_q;
  assign o_tx_power_down = tx_pd_q;
  assign o_tx_half_swing = swing_q;
  assign o_tx_line_encode_en = enc_q;
  assign o_rx_power_down = rx_pd_q;
  assign o_rx_line_decode_en = dec_q;
  assign o_rx_link_fsm_en = lsm_q;

  //////////////////////////////////////////////////////////////////////////////
  // parallel clock enables, one per quad and direction; a quad has a single
  // parallel clock, so the first channel of the quad sets its rate and the
  // second channel must be programmed alike
  for (genvar q = 0; q < SCR_NUM_QUAD; q++) begin : g_quad
    scr_div_if tx_div ();
    scr_div_if rx_div ();

    assign tx_div.quarter_sel = tx_q[2*q][SCR_TX_HALF_RATE_BIT];
    assign rx_div.quarter_sel = rx_q[2*q][SCR_RX_HALF_RATE_BIT];

    scr_clk_div u_tx_div (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .dv(tx_div.div)
    );

    scr_clk_div u_rx_div (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .dv(rx_div.div)
    );

    assign o_tx_pclk_en[q] = tx_div.pclk_en;
    assign o_rx_pclk_en[q] = rx_div.pclk_en;
  end

endmodule : scr_lane_cfg

`default_nettype wire

// ===== sim/scr_lane_cfg_assertions.sv
// concurrent checks on the ports of the lane configuration bank
`timescale 1ns/1ps
`default_nettype none
module scr_lane_cfg_assertions
  import scr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_mpi_req,
  input wire logic i_mpi_we,
  input wire logic [17:0] i_mpi_addr,
  input wire logic [7:0] i_mpi_wdata,
  input wire logic o_mpi_ack,
  input wire logic i_umi_req,
  input wire logic o_umi_ack,
  input wire logic [3:0] i_four_lane_mode_sel,
  input wire logic [3:0][4:0] o_tx_baud_mult,
  input wire logic [3:0] o_tx_power_down,
  input wire logic [3:0][4:0] o_rx_baud_mult,
  input wire logic [3:0] o_rx_link_fsm_en,
  input wire logic [1:0] o_tx_pclk_en,
  input wire logic [1:0] o_rx_pclk_en
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////
  ack_one_cycle_a: assert property (o_mpi_ack |=> !o_mpi_ack)
    else $error("processor ack held longer than one cycle");
  ack_timely_a: assert property (i_mpi_req && !o_mpi_ack |=> o_mpi_ack)
    else $error("processor request not acked next cycle");
  ack_cause_a: assert property (o_mpi_ack |-> $past(i_mpi_req))
    else $error("processor ack without request");
  umi_served_a: assert property (
    i_umi_req && !o_umi_ack && !(i_mpi_req && !o_mpi_ack) |=> o_umi_ack)
    else $error("user master request not acked while processor idle");
  link_mode_a: assert property (
    (o_rx_link_fsm_en & $past(i_four_lane_mode_sel)) == 4'h0)
    else $error("link state machine enabled in four lane mode");
  // fields lag the write edge by one cycle, so look two edges on
  tx_pd_follow_a: assert property (
    i_mpi_req && !o_mpi_ack && i_mpi_we && i_mpi_addr == SCR_LANE_TX_CFG_AC_OFS
    |-> ##2 o_tx_power_down[0] == $past(i_mpi_wdata[6], 2))
    else $error("transmit power down does not follow write");
  tx_pclk_full_a: assert property (
    o_tx_baud_mult[0] == 5'h14 [*2] ##1 (o_tx_pclk_en[0] && o_tx_baud_mult[0] == 5'h14)
    ##1 o_tx_baud_mult[0] == 5'h14 [*2] |-> o_tx_pclk_en[0] && !$past(o_tx_pclk_en[0]))
    else $error("transmit parallel clock not half of reference");
  rx_pclk_half_a: assert property (
    o_rx_baud_mult[2] == 5'h0a [*2] ##1 (o_rx_pclk_en[1] && o_rx_baud_mult[2] == 5'h0a)
    ##1 o_rx_baud_mult[2] == 5'h0a [*4] |-> o_rx_pclk_en[1] && !$past(o_rx_pclk_en[1], 2))
    else $error("receive parallel clock not quarter of reference");
endmodule : scr_lane_cfg_assertions
`default_nettype wire

// ===== sim/scr_host_model.sv
// bus master model for one register port of the lane configuration bank
`timescale 1ns/1ps
`default_nettype none
module scr_host_model
  import scr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_ack,
  input wire logic [SCR_DATA_W-1:0] i_rdata,
  output logic o_req,
  output logic o_we,
  output logic [SCR_ADDR_W-1:0] o_addr,
  output logic [SCR_DATA_W-1:0] o_wdata
);
  initial begin
    o_req = 1'b0;
    o_we = 1'b0;
    o_addr = '0;
    o_wdata = '0;
  end
  ////////////////////////////////////////
  // gap idles the port first, so slow masters are exercised as well
  task automatic access(input logic we, input logic [SCR_ADDR_W-1:0] a,
                        input logic [SCR_DATA_W-1:0] d, input int gap,
                        output logic [SCR_DATA_W-1:0] rd, output bit ok);
    int n;
    repeat (gap + 1) @(posedge i_clk);
    #1;
    o_req = 1'b1;
    o_we = we;
    o_addr = a;
    o_wdata = d;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ack !== 1'b1 && n < 20);
    rd = i_rdata;
    // a missing ack is reported to the caller, never taken as a finished access
    ok = (i_ack === 1'b1);
    #1;
    // a released bus shows the inverse, never a stale copy
    o_req = 1'b0;
    o_we = ~we;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : access
endmodule : scr_host_model
`default_nettype wire

// ===== sim/scr_lane_cfg_tb.sv
// self-checking bench for the lane configuration bank
`timescale 1ns/1ps
`default_nettype none
module scr_lane_cfg_tb
  import scr_pkg::*;
;
  logic clk, rst_n;
  logic [3:0] mode;
  logic [7:0] tx_m [4], rx_m [4];
  logic [17:0] bad [4] = '{18'h30024, 18'h30021, 18'h00022, 18'h31122};
  int num_errors = 0, num_checks = 0;
  wire logic m_req, m_we, m_ack, u_req, u_we, u_ack;
  wire logic [17:0] m_addr, u_addr;
  wire logic [7:0] m_wd, m_rd, u_wd, u_rd;
  wire logic [3:0][4:0] tx_bd, rx_bd;
  wire logic [3:0][1:0] emph;
  wire logic [3:0] tx_pd, swing, enc, rx_pd, dec, link;
  wire logic [1:0] tx_pe, rx_pe;
  scr_lane_cfg scr_lane_cfg_inst (.i_ref_clk(clk), .i_arst_n(rst_n),
    .i_mpi_req(m_req), .i_mpi_we(m_we), .i_mpi_addr(m_addr), .i_mpi_wdata(m_wd),
    .o_mpi_ack(m_ack), .o_mpi_rdata(m_rd), .i_umi_req(u_req), .i_umi_we(u_we),
    .i_umi_addr(u_addr), .i_umi_wdata(u_wd), .o_umi_ack(u_ack), .o_umi_rdata(u_rd),
    .i_four_lane_mode_sel(mode), .o_tx_baud_mult(tx_bd), .o_tx_power_down(tx_pd),
    .o_tx_emph_level(emph), .o_tx_half_swing(swing), .o_tx_line_encode_en(enc),
    .o_tx_pclk_en(tx_pe), .o_rx_baud_mult(rx_bd), .o_rx_power_down(rx_pd),
    .o_rx_line_decode_en(dec), .o_rx_link_fsm_en(link), .o_rx_pclk_en(rx_pe));
  scr_host_model host_mpi (.i_clk(clk), .i_ack(m_ack), .i_rdata(m_rd), .o_req(m_req),
    .o_we(m_we), .o_addr(m_addr), .o_wdata(m_wd));
  scr_host_model host_umi (.i_clk(clk), .i_ack(u_ack), .i_rdata(u_rd), .o_req(u_req),
    .o_we(u_we), .o_addr(u_addr), .o_wdata(u_wd));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t read got %h exp %h", $time, got, exp);
    end
  endtask : chk_rd
  task automatic chk_fld(input int c);
    logic [17:0] got, exp;
    got = {tx_bd[c], tx_pd[c], emph[c], swing[c], enc[c], rx_bd[c], rx_pd[c], dec[c], link[c]};
    exp = {tx_m[c][7] ? 5'h0a : 5'h14, tx_m[c][6], 2'(tx_m[c][5]) + 2'(tx_m[c][4]),
           tx_m[c][3], tx_m[c][0], rx_m[c][7] ? 5'h0a : 5'h14, rx_m[c][6], rx_m[c][4],
           rx_m[c][3] & ~mode[c]};
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t fields got %h exp %h", $time, got, exp);
    end
  endtask : chk_fld
  // quad rate follows the register of its first channel, 2*q; counts edges between two enable pulses
  task automatic chk_pclk(input int q, input bit rx);
    logic [1:0] pe;
    int n, want;
    want = (rx ? rx_m[2*q][7] : tx_m[2*q][7]) ? 4 : 2;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      pe = rx ? rx_pe : tx_pe;
      n++;
    end while (pe[q] !== 1'b1 && n < 8);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      pe = rx ? rx_pe : tx_pe;
      n++;
    end while (pe[q] !== 1'b1 && n < 8);
    num_checks++;
    if (n != want) begin
      num_errors++;
      $display("BAD %0t pclk got %h exp %h", $time, n, want);
    end
  endtask : chk_pclk
  task automatic xfer(input bit p, input logic we, input logic [17:0] a, input logic [7:0] d);
    logic [7:0] rd, e;
    int g;
    bit ok;
    g = $urandom_range(0, 2);
    if (p) host_umi.access(we, a, d, g, rd, ok);
    else host_mpi.access(we, a, d, g, rd, ok);
    if (!ok) begin
      num_errors++;
      $display("BAD %0t ack got %h exp %h", $time, 1'b0, 1'b1);
    end
    e = 8'h00;
    for (int c = 0; c < 4; c++) begin
      if (a === SCR_TX_OFS[c]) e = tx_m[c];
      if (a === SCR_RX_OFS[c]) e = rx_m[c];
      if (we && a === SCR_TX_OFS[c]) tx_m[c] = d;
      if (we && a === SCR_RX_OFS[c]) rx_m[c] = d & SCR_RX_RW_MASK;
    end
    if (!we) chk_rd(rd, e);
  endtask : xfer
  task automatic chk_all(input bit p);
    for (int c = 0; c < 4; c++) begin
      xfer(p, 1'b0, SCR_TX_OFS[c], 8'h00);
      xfer(p, 1'b0, SCR_RX_OFS[c], 8'h00);
      chk_fld(c);
    end
    for (int q = 0; q < 2; q++) begin
      chk_pclk(q, 1'b0);
      chk_pclk(q, 1'b1);
    end
  endtask : chk_all
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int c = 0; c < 4; c++) begin
      tx_m[c] = 8'h00;
      rx_m[c] = 8'h20;
    end
  endtask : do_reset
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////
  initial begin
    int c;
    rst_n = 1'b0;
    mode = 4'h0;
    void'($urandom(68));
    do_reset();
    chk_all(1'b0);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      xfer(k[0], 1'b1, SCR_LANE_TX_CFG_AC_OFS, {k[2], 1'b0, k[1], k[0], 4'h0});
      xfer(~k[0], 1'b1, SCR_LANE_RX_CFG_BC_OFS, {k[2], 7'h00});
      repeat (12) @(posedge clk);
      #1;
      chk_fld(0);
      chk_fld(2);
      chk_pclk(0, 1'b0);
      chk_pclk(1, 1'b1);
    end
    $display("test rates done");
    for (int i = 0; i < 40; i++) begin
      mode = 4'($urandom);
      c = $urandom_range(0, 3);
      // reserved transmit bit is kept clear, as software must
      if (i[0]) xfer(i[1], 1'b1, SCR_RX_OFS[c], 8'($urandom));
      else xfer(i[1], 1'b1, SCR_TX_OFS[c], 8'($urandom) & 8'hfb);
      xfer(~i[1], 1'b0, i[0] ? SCR_RX_OFS[c] : SCR_TX_OFS[c], 8'h00);
      chk_fld(c);
    end
    $display("test random done");
    for (int j = 0; j < 4; j++) begin
      xfer(j[0], 1'b1, bad[j], 8'hff);
      xfer(j[0], 1'b0, bad[j], 8'h00);
    end
    fork
      xfer(1'b0, 1'b1, SCR_LANE_TX_CFG_BD_OFS, 8'h81);
      xfer(1'b1, 1'b1, SCR_LANE_RX_CFG_AD_OFS, 8'h58);
    join
    chk_all(1'b1);
    $display("test unmapped and contention done");
    do_reset();
    chk_all(1'b1);
    $display("test second reset done");
    end_of_test();
  end
  initial begin
    #400000;
    num_errors++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule : scr_lane_cfg_tb
bind scr_lane_cfg scr_lane_cfg_assertions scr_lane_cfg_assertions_inst (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_mpi_req(i_mpi_req), .i_mpi_we(i_mpi_we),
  .i_mpi_addr(i_mpi_addr), .i_mpi_wdata(i_mpi_wdata), .o_mpi_ack(o_mpi_ack),
  .i_umi_req(i_umi_req), .o_umi_ack(o_umi_ack), .i_four_lane_mode_sel(i_four_lane_mode_sel),
  .o_tx_baud_mult(o_tx_baud_mult), .o_tx_power_down(o_tx_power_down),
  .o_rx_baud_mult(o_rx_baud_mult), .o_rx_link_fsm_en(o_rx_link_fsm_en),
  .o_tx_pclk_en(o_tx_pclk_en), .o_rx_pclk_en(o_rx_pclk_en));
`default_nettype wire
